//--- shared/tci_pkg.sv
// Constants and encodings shared by the timer capture/compare block and its interconnect.
// Assumes a single clock domain; all selector and pin inputs are synchronous to it.
package tci_pkg;
  localparam int CNT_W = 16;
  localparam int NUM_CH = 3;
  localparam int NUM_PADS = 4;
  localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  // Pad positions: group zero first, remapped group second
  localparam int PAD_G0_CH1 = 0;
  localparam int PAD_G0_CH2 = 1;
  localparam int PAD_G1_CH1 = 2;
  localparam int PAD_G1_CH2 = 3;
  localparam logic [NUM_PADS-1:0] PADS_OFF = 4'hF;
  // Capture edge field bits
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  // Counting modes, Gray ordered stop, up, continuous, up/down
  typedef enum logic [1:0] {
    MODE_STOP = 2'h0,
    MODE_UP = 2'h1,
    MODE_CONT = 2'h3,
    MODE_UPDN = 2'h2
  } tci_mode_e;
  // Counter clock sources
  typedef enum logic [1:0] {
    CLK_EXT = 2'h0,
    CLK_AUX = 2'h1,
    CLK_SUB = 2'h2,
    CLK_TOUCH = 2'h3
  } tci_clk_src_e;
  // Capture input choice
  typedef enum logic [1:0] {
    CAP_IN_A = 2'h0,
    CAP_IN_B = 2'h1,
    CAP_IN_GND = 2'h2,
    CAP_IN_VCC = 2'h3
  } tci_cap_in_e;
  // Infrared modulation mode and data source
  localparam logic IR_MODE_ASK = 1'b0;
  localparam logic IR_SRC_SERIAL = 1'b0;
endpackage

//--- hdl/tci_cc_channel.sv
// One capture/compare channel: compare register, capture logic, output unit.
// Assumes the counter value and its update strobe come from flip-flops of the parent.
`timescale 1ns/1ns
`default_nettype none
module tci_cc_channel #(
  parameter int W = tci_pkg::CNT_W
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Counter view
  input wire logic [W-1:0] count,
  input wire logic count_upd,
  input wire logic period_hit,
  // Configuration
  input wire logic cap_mode,
  input wire logic [1:0] cap_edge,
  input wire logic [1:0] cap_in_sel,
  input wire logic cci_a,
  input wire logic cci_b,
  input wire logic cc_wr,
  input wire logic [W-1:0] cc_wdata,
  input wire logic out_mode,
  input wire logic out_bit,
  // Results
  output logic [W-1:0] cc_value,
  output logic cc_event,
  output logic cc_out
);
  logic cap_in;
  logic edge_hit;
  logic match;
  logic cap_prev_reg, cap_prev_next;
  logic [W-1:0] ccr_reg, ccr_next;
  logic event_reg, event_next;
  logic out_reg, out_next;

  // Capture, compare and output next state
  always_comb begin
    unique case (cap_in_sel)
      tci_pkg::CAP_IN_A: cap_in = cci_a;
      tci_pkg::CAP_IN_B: cap_in = cci_b;
      tci_pkg::CAP_IN_GND: cap_in = 1'b0;
      tci_pkg::CAP_IN_VCC: cap_in = 1'b1;
    endcase
    // Switching the selector can itself look like an edge
    edge_hit = (cap_edge[tci_pkg::EDGE_RISE_BIT] & cap_in & ~cap_prev_reg) |
               (cap_edge[tci_pkg::EDGE_FALL_BIT] & ~cap_in & cap_prev_reg);
    match = count_upd & (count == ccr_reg);
    cap_prev_next = cap_in;
    ccr_next = ccr_reg;
    event_next = 1'b0;
    out_next = out_reg;
    if (cap_mode) begin
      if (edge_hit) begin
        ccr_next = count;
        event_next = 1'b1;
      end
    end else begin
      if (cc_wr) begin
        ccr_next = cc_wdata;
      end
      if (match) begin
        event_next = 1'b1;
      end
    end
    // Reset/set PWM: own match clears, period restart sets; clear wins
    if (!out_mode) begin
      out_next = out_bit;
    end else if (match) begin
      out_next = 1'b0;
    end else if (period_hit) begin
      out_next = 1'b1;
    end
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cap_prev_reg <= 1'b0;
      ccr_reg <= '0;
      event_reg <= 1'b0;
      out_reg <= 1'b0;
    end else begin
      cap_prev_reg <= cap_prev_next;
      ccr_reg <= ccr_next;
      event_reg <= event_next;
      out_reg <= out_next;
    end
  end

  assign cc_value = ccr_reg;
  assign cc_event = event_reg;
  assign cc_out = out_reg;

  // Checks
  property p_cap_take;
    @(posedge clk_sys) disable iff (!rst_n)
      (cap_mode && edge_hit) |=> (ccr_reg == $past(count)) && event_reg;
  endproperty
  a_cap_take: assert property (p_cap_take) else $error("capture lost");
  property p_pwm_clear;
    @(posedge clk_sys) disable iff (!rst_n)
      (out_mode && match) |=> !out_reg;
  endproperty
  a_pwm_clear: assert property (p_pwm_clear) else $error("pwm not cleared");
  // Period restart sets the output only when the own match is absent
  property p_pwm_set;
    @(posedge clk_sys) disable iff (!rst_n)
      (out_mode && period_hit && !match) |=> out_reg;
  endproperty
  a_pwm_set: assert property (p_pwm_set) else $error("pwm not set");
  c_capture: cover property (@(posedge clk_sys) disable iff (!rst_n) cap_mode && edge_hit);
endmodule
`default_nettype wire

//--- hdl/tci_timer_ccr_interconnect.sv
// Timer counter, three capture/compare channels and their on-chip wiring:
// clock select, capture routing with pin remap, infrared modulation, pad high-impedance.
// Assumes all sources, pins and controls are synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
module tci_timer_ccr_interconnect #(
  parameter int W = tci_pkg::CNT_W,
  parameter int NCH = tci_pkg::NUM_CH
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Counter clock sources and control
  input wire logic ext_timer_clock,
  input wire logic aux_clock,
  input wire logic subsystem_clock,
  input wire logic touch_block_clock,
  input wire logic [1:0] clk_src_sel,
  input wire logic [1:0] count_mode,
  input wire logic timer_clear,
  // Channel configuration
  input wire logic [NCH-1:0] cap_mode,
  input wire logic [2*NCH-1:0] cap_edge,
  input wire logic [2*NCH-1:0] cap_in_sel,
  input wire logic [NCH-1:0] cc_wr,
  input wire logic [W-1:0] cc_wdata,
  input wire logic [NCH-1:0] out_mode,
  input wire logic [NCH-1:0] out_bit,
  // Internal event sources
  input wire logic rtc_overflow_evt,
  input wire logic comparator_out,
  input wire logic touch_capture_in,
  // Pads, group zero then remapped group
  input wire logic [3:0] pad_in,
  input wire logic [3:0] pin_function_select,
  input wire logic timer_pin_remap_sel,
  output logic [3:0] pad_out,
  output logic [3:0] pad_oe_n,
  // High-impedance trigger
  input wire logic hiz_trigger_sel,
  input wire logic hiz_ext_pin,
  output logic hiz_request,
  // Infrared modulation of serial transmit
  input wire logic serial_tx_in,
  input wire logic infrared_enable,
  input wire logic infrared_polarity_sel,
  input wire logic infrared_mode_sel,
  input wire logic infrared_data_source_sel,
  input wire logic infrared_sw_data_bit,
  output logic serial_tx_dataout_pin,
  // Results and interrupt pulses
  output logic [W-1:0] count_value,
  output logic [W-1:0] cc_channel_zero,
  output logic [W-1:0] cc_channel_one,
  output logic [W-1:0] cc_channel_two,
  output logic overflow_irq,
  output logic [NCH-1:0] cc_irq,
  output logic adc_trigger
);
  logic [W-1:0] cc_val [NCH];
  logic [NCH-1:0] cc_out;
  logic [NCH-1:0] cci_a;
  logic [NCH-1:0] cci_b;
  logic src_lvl;
  logic tick;
  logic period_hit;
  logic hiz_next;
  logic ir_data;
  logic ir_mod;
  logic [3:0] pad_src;
  logic src_prev_reg, src_prev_next;
  logic [W-1:0] count_reg, count_next;
  logic down_reg, down_next;
  logic upd_reg, upd_next;
  logic ovf_reg, ovf_next;
  logic hiz_reg;
  logic [3:0] pad_out_reg, pad_out_next;
  logic [3:0] pad_oe_n_reg, pad_oe_n_next;
  logic tx_reg, tx_next;
  logic adc_reg, adc_next;

  // Capture routing; channel zero input A is the real-time counter overflow
  always_comb begin
    cci_a[0] = rtc_overflow_evt;
    cci_b[0] = aux_clock;
    cci_a[1] = timer_pin_remap_sel ? pad_in[tci_pkg::PAD_G1_CH1] : pad_in[tci_pkg::PAD_G0_CH1];
    cci_a[2] = timer_pin_remap_sel ? pad_in[tci_pkg::PAD_G1_CH2] : pad_in[tci_pkg::PAD_G0_CH2];
    cci_b[1] = comparator_out;
    cci_b[2] = touch_capture_in;
  end

  // One channel per compare register
  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      tci_cc_channel #(.W(W)) u_ch (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .count(count_reg),
        .count_upd(upd_reg),
        .period_hit(period_hit),
        .cap_mode(cap_mode[gi]),
        .cap_edge(cap_edge[2*gi+:2]),
        .cap_in_sel(cap_in_sel[2*gi+:2]),
        .cci_a(cci_a[gi]),
        .cci_b(cci_b[gi]),
        .cc_wr(cc_wr[gi]),
        .cc_wdata(cc_wdata),
        .out_mode(out_mode[gi]),
        .out_bit(out_bit[gi]),
        .cc_value(cc_val[gi]),
        .cc_event(cc_irq[gi]),
        .cc_out(cc_out[gi])
      );
    end
  endgenerate

  // Counter: source edge detect and mode sequencing
  always_comb begin
    unique case (clk_src_sel)
      tci_pkg::CLK_EXT: src_lvl = ext_timer_clock;
      tci_pkg::CLK_AUX: src_lvl = aux_clock;
      tci_pkg::CLK_SUB: src_lvl = subsystem_clock;
      tci_pkg::CLK_TOUCH: src_lvl = touch_block_clock;
    endcase
    src_prev_next = src_lvl;
    // Sources up to half of clk_sys only; faster ones alias
    tick = src_lvl & ~src_prev_reg & (count_mode != tci_pkg::MODE_STOP);
    period_hit = upd_reg & (count_reg == cc_val[0]);
    count_next = count_reg;
    down_next = down_reg;
    ovf_next = 1'b0;
    upd_next = tick;
    if (timer_clear) begin
      count_next = tci_pkg::CNT_RST;
      down_next = 1'b0;
      upd_next = 1'b0;
    end else if (tick) begin
      unique case (count_mode)
        tci_pkg::MODE_UP: begin
          // Beyond the period, restart rather than run to the top
          if (count_reg >= cc_val[0]) begin
            count_next = tci_pkg::CNT_RST;
            ovf_next = 1'b1;
          end else begin
            count_next = W'(count_reg + tci_pkg::CNT_ONE);
          end
        end
        tci_pkg::MODE_CONT: begin
          count_next = W'(count_reg + tci_pkg::CNT_ONE);
          ovf_next = (count_reg == tci_pkg::CNT_MAX);
        end
        tci_pkg::MODE_UPDN: begin
          if (!down_reg && count_reg >= cc_val[0]) begin
            down_next = 1'b1;
            count_next = W'(count_reg - tci_pkg::CNT_ONE);
          end else if (down_reg && count_reg == tci_pkg::CNT_RST) begin
            down_next = 1'b0;
            count_next = W'(count_reg + tci_pkg::CNT_ONE);
            ovf_next = 1'b1;
          end else if (down_reg) begin
            count_next = W'(count_reg - tci_pkg::CNT_ONE);
          end else begin
            count_next = W'(count_reg + tci_pkg::CNT_ONE);
          end
        end
        tci_pkg::MODE_STOP: count_next = count_reg;
      endcase
    end
  end

  // Pads, high-impedance trigger, infrared and ADC trigger
  always_comb begin
    hiz_next = hiz_trigger_sel ? hiz_ext_pin : comparator_out;
    // Channel zero has no pad; both groups carry channels one and two
    pad_src = {cc_out[2], cc_out[1], cc_out[2], cc_out[1]};
    for (int i = 0; i < tci_pkg::NUM_PADS; i++) begin
      pad_oe_n_next[i] = hiz_next | ~pin_function_select[i];
      pad_out_next[i] = pin_function_select[i] & ~hiz_next & pad_src[i];
    end
    ir_data = (infrared_data_source_sel == tci_pkg::IR_SRC_SERIAL) ?
              serial_tx_in : infrared_sw_data_bit;
    // ASK gates the channel one carrier; FSK picks carrier one or two
    if (infrared_mode_sel == tci_pkg::IR_MODE_ASK) begin
      ir_mod = ir_data & cc_out[1];
    end else begin
      ir_mod = ir_data ? cc_out[1] : cc_out[2];
    end
    tx_next = infrared_enable ? (ir_mod ^ infrared_polarity_sel) : serial_tx_in;
    adc_next = cc_out[1];
  end

  // Register stage
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      src_prev_reg <= 1'b0;
      count_reg <= tci_pkg::CNT_RST;
      down_reg <= 1'b0;
      upd_reg <= 1'b0;
      ovf_reg <= 1'b0;
      hiz_reg <= 1'b0;
      pad_out_reg <= '0;
      pad_oe_n_reg <= tci_pkg::PADS_OFF;
      tx_reg <= 1'b1;
      adc_reg <= 1'b0;
    end else begin
      src_prev_reg <= src_prev_next;
      count_reg <= count_next;
      down_reg <= down_next;
      upd_reg <= upd_next;
      ovf_reg <= ovf_next;
      hiz_reg <= hiz_next;
      pad_out_reg <= pad_out_next;
      pad_oe_n_reg <= pad_oe_n_next;
      tx_reg <= tx_next;
      adc_reg <= adc_next;
    end
  end

  assign count_value = count_reg;
  assign cc_channel_zero = cc_val[0];
  assign cc_channel_one = cc_val[1];
  assign cc_channel_two = cc_val[2];
  assign overflow_irq = ovf_reg;
  assign hiz_request = hiz_reg;
  assign pad_out = pad_out_reg;
  assign pad_oe_n = pad_oe_n_reg;
  assign serial_tx_dataout_pin = tx_reg;
  assign adc_trigger = adc_reg;

  // Checks
  property p_up_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && !timer_clear && count_mode == tci_pkg::MODE_UP && count_reg == cc_val[0])
      |=> (count_reg == tci_pkg::CNT_RST) && ovf_reg;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up mode wrap wrong");
  property p_cont_wrap;
    @(posedge clk_sys) disable iff (!rst_n)
      (tick && !timer_clear && count_mode == tci_pkg::MODE_CONT && count_reg == tci_pkg::CNT_MAX)
      |=> (count_reg == tci_pkg::CNT_RST) && ovf_reg ##1 !ovf_reg;
  endproperty
  a_cont_wrap: assert property (p_cont_wrap) else $error("overflow pulse wrong");
  property p_hiz_all;
    @(posedge clk_sys) disable iff (!rst_n)
      hiz_reg |-> (pad_oe_n_reg == tci_pkg::PADS_OFF) && (pad_out_reg == '0);
  endproperty
  a_hiz_all: assert property (p_hiz_all) else $error("pad driven while floated");
  property p_hiz_src;
    @(posedge clk_sys) disable iff (!rst_n)
      (!hiz_trigger_sel && comparator_out) or (hiz_trigger_sel && hiz_ext_pin) |=> hiz_reg;
  endproperty
  a_hiz_src: assert property (p_hiz_src) else $error("trigger source ignored");
  property p_both_groups;
    @(posedge clk_sys) disable iff (!rst_n)
      (pin_function_select[0] && pin_function_select[2] && !hiz_next)
      |=> !pad_oe_n_reg[0] && !pad_oe_n_reg[2] && (pad_out_reg[0] == pad_out_reg[2]);
  endproperty
  a_both_groups: assert property (p_both_groups) else $error("groups differ");
  property p_fsel_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !pin_function_select[1] |=> pad_oe_n_reg[1] && !pad_out_reg[1];
  endproperty
  a_fsel_off: assert property (p_fsel_off) else $error("unselected pad driven");
  property p_ir_off;
    @(posedge clk_sys) disable iff (!rst_n)
      !infrared_enable |=> serial_tx_dataout_pin == $past(serial_tx_in);
  endproperty
  a_ir_off: assert property (p_ir_off) else $error("tx not passed through");
  property p_ir_ask_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (infrared_enable && infrared_data_source_sel && !infrared_sw_data_bit &&
       infrared_mode_sel == tci_pkg::IR_MODE_ASK) |=> tx_reg == $past(infrared_polarity_sel);
  endproperty
  a_ir_ask_zero: assert property (p_ir_ask_zero) else $error("ask idle level wrong");
  property p_adc_follow;
    @(posedge clk_sys) disable iff (!rst_n)
      $changed(cc_out[1]) |=> adc_reg == $past(cc_out[1]);
  endproperty
  a_adc_follow: assert property (p_adc_follow) else $error("adc trigger lags");
  c_overflow: cover property (@(posedge clk_sys) disable iff (!rst_n) ovf_reg);
  c_hiz: cover property (@(posedge clk_sys) disable iff (!rst_n) hiz_reg);
  c_ir_fsk: cover property (@(posedge clk_sys) disable iff (!rst_n)
    infrared_enable && infrared_mode_sel && tx_reg);
endmodule
`default_nettype wire

//--- verification/tci_partner.sv
// Far-side model: the four counter clock sources and real-time counter overflow events.
// Assumes the bench raises requests between rising edges of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module tci_partner (
  // Clock
  input wire logic clk_sys,
  // Requests from the bench
  input wire logic tick_go,
  input wire logic [1:0] tick_src,
  input wire logic rtc_go,
  // Sources toward the timer
  output logic [3:0] src_clk,
  output logic rtc_overflow_evt
);
  int phase = 0;
  logic [3:0] src_reg = 4'h0;
  logic rtc_reg = 1'b0;
  // Sources stand low between ticks; two high then at least three low cycles
  // so the timer always sees a low sample before the next edge
  always @(posedge clk_sys) begin
    rtc_reg <= rtc_go;
    if (phase > 0) begin
      phase <= phase - 1;
      if (phase == 3) begin
        src_reg <= 4'h0;
      end
    end else if (tick_go) begin
      src_reg[tick_src] <= 1'b1;
      phase <= 4;
    end
  end

  // One driver per output
  assign src_clk = src_reg;
  assign rtc_overflow_evt = rtc_reg;
endmodule
`default_nettype wire

//--- verification/tci_timer_ccr_interconnect_test.sv
// Self-checking bench: counter, capture routing, pads, high impedance, infrared, ADC trigger.
// Assumes the partner model makes the clock sources and rtc overflow; all other inputs driven at falling edges.
`timescale 1ns/1ns
`default_nettype none
module tci_timer_ccr_interconnect_test;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic tick_go = 1'b0;
  logic [1:0] tick_src = 2'h0;
  logic rtc_go = 1'b0;
  logic [1:0] clk_src_sel = 2'h0;
  logic [1:0] count_mode = 2'h0;
  logic [2:0] cap_mode = 3'h0;
  logic [5:0] cap_edge = 6'h15;
  logic [5:0] cap_in_sel = 6'h00;
  logic [2:0] cc_wr = 3'h0;
  logic [15:0] cc_wdata = 16'h0000;
  logic [2:0] out_mode = 3'h0;
  logic [2:0] out_bit = 3'h0;
  logic comparator_out = 1'b0;
  logic touch_in = 1'b0;
  logic [3:0] pad_in = 4'h0;
  logic [3:0] pin_function_select = 4'h0;
  logic timer_pin_remap_sel = 1'b0;
  logic hiz_trigger_sel = 1'b0;
  logic hiz_ext_pin = 1'b0;
  logic serial_tx_in = 1'b1;
  logic ir_en = 1'b0, ir_pol = 1'b0, ir_mode = 1'b0, ir_ds = 1'b0, ir_sw = 1'b0;
  logic [3:0] src_clk;
  logic rtc_evt, overflow_irq, adc_trigger, hiz_request, serial_tx_dataout_pin;
  logic [15:0] count_value, cc0, cc1, cc2;
  logic [2:0] cc_irq;
  logic [3:0] pad_out, pad_oe_n;
  int error_cnt = 0, compares = 0, ov_seen = 0, m_ov = 0, m_cnt = 0, m_dn = 0, m_pwm = 0;
  int irq_seen[3] = '{default: 0};
  int m_irq[3] = '{default: 0};
  int m_cc[3] = '{default: 0};
  logic [31:0] seed = 32'h0000_85B5;

  // 125 MHz system clock
  always #4 clk_sys = ~clk_sys;

  tci_partner far_side (.clk_sys(clk_sys), .tick_go(tick_go), .tick_src(tick_src),
    .rtc_go(rtc_go), .src_clk(src_clk), .rtc_overflow_evt(rtc_evt));

  tci_timer_ccr_interconnect dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .ext_timer_clock(src_clk[0]), .aux_clock(src_clk[1]), .subsystem_clock(src_clk[2]),
    .touch_block_clock(src_clk[3]), .clk_src_sel(clk_src_sel), .count_mode(count_mode),
    .timer_clear(1'b0), .cap_mode(cap_mode), .cap_edge(cap_edge), .cap_in_sel(cap_in_sel),
    .cc_wr(cc_wr), .cc_wdata(cc_wdata), .out_mode(out_mode), .out_bit(out_bit),
    .rtc_overflow_evt(rtc_evt), .comparator_out(comparator_out), .touch_capture_in(touch_in),
    .pad_in(pad_in), .pin_function_select(pin_function_select),
    .timer_pin_remap_sel(timer_pin_remap_sel), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .hiz_trigger_sel(hiz_trigger_sel), .hiz_ext_pin(hiz_ext_pin), .hiz_request(hiz_request),
    .serial_tx_in(serial_tx_in), .infrared_enable(ir_en), .infrared_polarity_sel(ir_pol),
    .infrared_mode_sel(ir_mode), .infrared_data_source_sel(ir_ds),
    .infrared_sw_data_bit(ir_sw), .serial_tx_dataout_pin(serial_tx_dataout_pin),
    .count_value(count_value), .cc_channel_zero(cc0), .cc_channel_one(cc1),
    .cc_channel_two(cc2), .overflow_irq(overflow_irq), .cc_irq(cc_irq),
    .adc_trigger(adc_trigger));

  // Pulse counters; flags stand one cycle so every edge is looked at
  always @(posedge clk_sys) begin
    if (overflow_irq === 1'b1) ov_seen++;
    for (int i = 0; i < 3; i++) if (cc_irq[i] === 1'b1) irq_seen[i]++;
  end

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [15:0] ccv(input int ch);
    return (ch == 0) ? cc0 : (ch == 1) ? cc1 : cc2;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic give_verdict();
    $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // One source tick; the model advances only for the selected running source
  task automatic tick(input int s);
    @(negedge clk_sys) tick_go = 1'b1;
    tick_src = s[1:0];
    @(negedge clk_sys) tick_go = 1'b0;
    if (s == int'(clk_src_sel) && count_mode != 2'h0) begin
      if (count_mode == 2'h1 && m_cnt >= m_cc[0]) begin
        m_cnt = 0;
        m_ov++;
      end else if (count_mode == 2'h2 && m_dn == 0 && m_cnt >= m_cc[0]) begin
        m_dn = 1;
        m_cnt--;
      end else if (count_mode == 2'h2 && m_dn == 1 && m_cnt == 0) begin
        m_dn = 0;
        m_cnt = 1;
        m_ov++;
      end else if (count_mode == 2'h2 && m_dn == 1) begin
        m_cnt--;
      end else begin
        m_cnt = (m_cnt + 1) % 65536;
      end
      for (int i = 0; i < 3; i++) if (!cap_mode[i] && m_cnt == m_cc[i]) m_irq[i]++;
      // Channel one reset/set output: own match clears, period match sets
      if (m_cnt == m_cc[1]) m_pwm = 0;
      else if (m_cnt == m_cc[0]) m_pwm = 1;
    end
    repeat (5) @(negedge clk_sys);
    chk(count_value, 16'(m_cnt));
    chk(16'(ov_seen), 16'(m_ov));
    if (out_mode[1]) chk(16'(pad_out[0]), 16'(m_pwm));
  endtask

  task automatic wr(input int ch, input int v);
    @(negedge clk_sys) cc_wr = 3'h1 << ch;
    cc_wdata = 16'(v);
    @(negedge clk_sys) cc_wr = 3'h0;
    m_cc[ch] = v;
    chk(ccv(ch), 16'(v));
  endtask

  // Capture event on one source: rtc, comparator, group-zero pad, group-one pad or touch
  task automatic pulse(input int src);
    @(negedge clk_sys);
    case (src)
      0: rtc_go = 1'b1;
      1: comparator_out = 1'b1;
      2: pad_in[0] = 1'b1;
      4: pad_in[1] = 1'b1;
      5: touch_in = 1'b1;
      default: pad_in[2] = 1'b1;
    endcase
    @(negedge clk_sys) rtc_go = 1'b0;
    @(negedge clk_sys) comparator_out = 1'b0;
    pad_in = 4'h0;
    touch_in = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    error_cnt++;
    give_verdict();
  end

  initial begin
    static int c_ch[9] = '{0, 1, 1, 1, 1, 1, 2, 2, 2};
    static int c_src[9] = '{0, 1, 2, 3, 3, 2, 4, 4, 5};
    static int c_rmp[9] = '{0, 0, 0, 0, 1, 1, 0, 1, 0};
    static int c_sel[9] = '{0, 1, 0, 0, 0, 0, 0, 3, 1};
    static int c_hit[9] = '{1, 1, 1, 0, 1, 0, 1, 1, 1};
    logic [31:0] r;
    logic hz, d, md;
    logic [3:0] e_oe, e_o;
    repeat (20) @(negedge clk_sys);
    chk(count_value, 16'h0000);
    chk(16'(pad_oe_n), 16'h000F);
    chk(16'(serial_tx_dataout_pin), 16'h0001);
    rst_n = 1'b1;
    $display("Test reset done");
    // Up mode wrap at channel zero, all four clock sources
    wr(0, 2);
    wr(1, 1);
    wr(2, 2);
    count_mode = 2'h1;
    out_mode = 3'h2;
    pin_function_select = 4'h1;
    for (int sel = 0; sel < 4; sel++) begin
      clk_src_sel = 2'(sel);
      for (int s = 0; s < 4; s++) tick(s);
      tick(sel);
      tick(sel);
    end
    // Up/down: turn at channel zero value, overflow on leaving zero upward
    count_mode = 2'h2;
    repeat (8) tick(3);
    for (int i = 0; i < 3; i++) chk(16'(irq_seen[i]), 16'(m_irq[i]));
    $display("Test counting done");
    // Capture routing with pin remap
    clk_src_sel = 2'h0;
    count_mode = 2'h3;
    cap_mode = 3'h7;
    out_mode = 3'h0;
    // Last entries: channel two pad, supply select edge, touch input B
    for (int k = 0; k < 9; k++) begin
      tick(0);
      timer_pin_remap_sel = c_rmp[k][0];
      cap_in_sel[2*c_ch[k] +: 2] = 2'(c_sel[k]);
      pulse(c_src[k]);
      if (c_hit[k] == 1) begin
        m_cc[c_ch[k]] = m_cnt;
        m_irq[c_ch[k]]++;
      end
      chk(ccv(c_ch[k]), 16'(m_cc[c_ch[k]]));
      chk(16'(irq_seen[c_ch[k]]), 16'(m_irq[c_ch[k]]));
    end
    $display("Test capture done");
    // Random pad, high impedance, infrared and ADC trigger settings
    count_mode = 2'h0;
    cap_mode = 3'h0;
    for (int n = 0; n < 40; n++) begin
      r = xs();
      @(negedge clk_sys) pin_function_select = r[3:0];
      {timer_pin_remap_sel, hiz_trigger_sel, comparator_out, hiz_ext_pin} = r[7:4];
      out_bit = r[10:8];
      {serial_tx_in, ir_en, ir_pol, ir_mode, ir_ds, ir_sw} = r[16:11];
      repeat (4) @(negedge clk_sys);
      hz = hiz_trigger_sel ? hiz_ext_pin : comparator_out;
      for (int p = 0; p < 4; p++) begin
        e_oe[p] = hz | !pin_function_select[p];
        e_o[p] = pin_function_select[p] & !hz & ((p % 2 == 0) ? out_bit[1] : out_bit[2]);
      end
      d = (ir_ds == tci_pkg::IR_SRC_SERIAL) ? serial_tx_in : ir_sw;
      md = (ir_mode == tci_pkg::IR_MODE_ASK) ? (d & out_bit[1]) : (d ? out_bit[1] : out_bit[2]);
      chk(16'(pad_oe_n), 16'(e_oe));
      chk(16'(pad_out), 16'(e_o));
      chk(16'(hiz_request), 16'(hz));
      chk(16'(serial_tx_dataout_pin), 16'(ir_en ? (md ^ ir_pol) : serial_tx_in));
      chk(16'(adc_trigger), 16'(out_bit[1]));
    end
    $display("Test pads done");
    give_verdict();
  end
endmodule
`default_nettype wire
